// ---- rtl/gpio_pkg.sv ----
// Constants and helpers shared by the parallel port block
// Operation
// R1: General port pin drives when its direction bit is one, else input.
// R2: Each 8-bit general port has its own 8-bit direction register.
// R3: Reset clears every direction register, making all general pins inputs.
// R4: Processor can write and read back every direction register.
// R5: Data writes always load the latch; pin shows it only when direction is one.
// R6: Data read returns latch for output pins, live pin level for inputs.
// R7: First port pins go open-drain when special bit 0 and direction set.
// R8: Wired-or select makes special lines 2-5 open-drain when outputs.
// R9: With SPI disabled, special lines 2-5 follow their own direction bits.
// R10: Special lines 0, 6 and 7 are inputs with no programmable direction.
// R11: Once timer oscillator enabled, line 1 is output until reset; line 0 input.
// R12: Special direction bits 0, 1, 6, 7 ignore writes and read zero.
// R13: With SPI enabled line 5 is slave select; in slave mode direction ignored.
// R14: In SPI master mode line 5 is fault input if direction clear, else output.
// R15: SPI input lines 2-4 stay inputs; SPI output lines drive only if direction set.
// R16: Reads of undefined or unused bits return zero.
// R17: Input mode disables the driver while the latch keeps its last value.
package gpio_pkg;
  localparam int         PORT_W      = 8;
  localparam logic [3:0] SEL_A_DATA  = 4'h0;
  localparam logic [3:0] SEL_A_DIR   = 4'h1;
  localparam logic [3:0] SEL_B_DATA  = 4'h2;
  localparam logic [3:0] SEL_B_DIR   = 4'h3;
  localparam logic [3:0] SEL_C_DATA  = 4'h4;
  localparam logic [3:0] SEL_C_DIR   = 4'h5;
  localparam logic [3:0] SEL_D_DATA  = 4'h6;
  localparam logic [3:0] SEL_D_DIR   = 4'h7;
  localparam logic [3:0] SEL_SPECIAL = 4'h8;
  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SPEC_RESET  = 8'h00;
  localparam logic [7:0] ALL_MASK    = 8'hff;
  localparam logic [7:0] D_DIR_MASK  = 8'h3c;
  localparam logic [7:0] D_READ_MASK = 8'hbf;
  localparam logic [7:0] SPEC_MASK   = 8'h05;
  localparam int         SPEC_OD_BIT = 0;
  localparam int         SPEC_DLY_BIT = 2;
  localparam int         D_OSC_OUT   = 1;
  localparam int         D_MISO      = 2;
  localparam int         D_MOSI      = 3;
  localparam int         D_SCK       = 4;
  localparam int         D_SS        = 5;

  function automatic logic [7:0] port_read(logic [7:0] dir, logic [7:0] latch,
                                           logic [7:0] pin);
    return (dir & latch) | (~dir & pin);
  endfunction

  // Returns {output enable, output level}
  function automatic logic [1:0] drive_bit(logic want, logic val, logic od);
    if (od)
      return {want & ~val, 1'b0};
    return {want, val};
  endfunction
endpackage

// ---- rtl/port_ctl_if.sv ----
// Control and state link between the port block and one port slice
`timescale 1ns/1ps
interface port_ctl_if;
  import gpio_pkg::*;
  logic [PORT_W-1:0] wdata;     // Write data
  logic              ldDir;     // Load direction register
  logic              ldLatch;   // Load output latch
  logic              openDrain; // Open-drain drive mode
  logic [PORT_W-1:0] dir;       // Direction register
  logic [PORT_W-1:0] latch;     // Output latch
  logic [PORT_W-1:0] pinLevel;  // Synchronised pin level
  modport ctl  (output wdata, ldDir, ldLatch, openDrain, input dir, latch, pinLevel);
  modport port (input wdata, ldDir, ldLatch, openDrain, output dir, latch, pinLevel);
endinterface

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync
  import gpio_pkg::*;
(
  input  wire logic              clock, // System clock
  input  wire logic              rstn,  // Async reset, active low
  input  wire logic [PORT_W-1:0] async, // Raw pin levels
  output logic      [PORT_W-1:0] level  // Filtered level
);
  logic [PORT_W-1:0] s1;
  logic [PORT_W-1:0] s2;
  logic [PORT_W-1:0] s3;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit that still disagrees keeps its old value, so one-cycle glitches vanish
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      level <= '0;
    else
      level <= (s2 & s3) | (level & (s2 ^ s3));
  end
endmodule

// ---- rtl/gp_port.sv ----
// One 8-bit port slice: direction register, output latch, pin sampling and drive
`timescale 1ns/1ps
module gp_port
  import gpio_pkg::*;
#(
  parameter logic [PORT_W-1:0] DIR_MASK = ALL_MASK
)
(
  input  wire logic              clock,  // System clock
  input  wire logic              rstn,   // Async reset, active low
  port_ctl_if.port               ctl,    // Control link
  input  wire logic [PORT_W-1:0] pinIn,  // Pin input levels
  output logic      [PORT_W-1:0] pinOut, // Pin output levels
  output logic      [PORT_W-1:0] pinOe   // Pin output enables
);
  logic [PORT_W-1:0] next_oe;
  logic [PORT_W-1:0] next_out;

  pin_sync u_sync (
    .clock (clock),
    .rstn  (rstn),
    .async (pinIn),
    .level (ctl.pinLevel)
  );

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ctl.dir <= DIR_RESET;                                       // [R3]
    else if (ctl.ldDir)
      ctl.dir <= ctl.wdata & DIR_MASK;                            // [R2] [R4] [R12]
  end

  // The latch loads whatever the direction, so it is ready before the pin turns
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ctl.latch <= LATCH_RESET;
    else if (ctl.ldLatch)
      ctl.latch <= ctl.wdata;                                     // [R5] [R17]
  end

  always_comb
  begin
    next_oe = '0;
    next_out = '0;
    for (int i = 0; i < PORT_W; i++)
      {next_oe[i], next_out[i]} = drive_bit(ctl.dir[i], ctl.latch[i], ctl.openDrain); // [R1] [R7]
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pinOe <= '0;
      pinOut <= '0;
    end
    else
    begin
      pinOe <= next_oe;
      pinOut <= next_out;
    end
  end

  property p_dirLoad;
    @(posedge clock) disable iff (!rstn)
    ctl.ldDir |=> ctl.dir == ($past(ctl.wdata) & DIR_MASK);
  endproperty
  a_dirLoad: assert property (p_dirLoad) else $error("direction load wrong"); // [R4]

  property p_resetDir;
    @(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> ctl.dir == DIR_RESET && pinOe == '0;
  endproperty
  a_resetDir: assert property (p_resetDir) else $error("direction not cleared"); // [R3]

  property p_inputHiZ;
    @(posedge clock) disable iff (!rstn)
    !ctl.ldLatch ##1 !ctl.ldLatch |-> (pinOe & ~$past(ctl.dir)) == '0 &&
                                      ctl.latch == $past(ctl.latch);
  endproperty
  a_inputHiZ: assert property (p_inputHiZ) else $error("input pin driven"); // [R17]

  property p_pushPull;
    @(posedge clock) disable iff (!rstn)
    !ctl.openDrain |=> pinOe == $past(ctl.dir) && pinOut == $past(ctl.latch);
  endproperty
  a_pushPull: assert property (p_pushPull) else $error("push-pull drive wrong"); // [R5]

  property p_openDrain;
    @(posedge clock) disable iff (!rstn)
    ctl.openDrain |=> pinOut == '0 && pinOe == ($past(ctl.dir) & ~$past(ctl.latch));
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("open-drain drive wrong"); // [R7]
endmodule

// ---- rtl/parallel_io_ports.sv ----
// Three general ports and the special port shared with the SPI and timer oscillator
`timescale 1ns/1ps
module parallel_io_ports
  import gpio_pkg::*;
(
  input  wire logic              clock,              // 100 MHz system clock
  input  wire logic              rstn,               // Async reset, active low
  input  wire logic [3:0]        regSel,             // Register select
  input  wire logic              regWr,              // Register write strobe
  input  wire logic              regRd,              // Register read strobe
  input  wire logic [PORT_W-1:0] regWdata,           // Register write data
  output logic      [PORT_W-1:0] regRdata,           // Read data, held
  input  wire logic [PORT_W-1:0] firstPortPinsIn,    // First port pin levels
  output logic      [PORT_W-1:0] firstPortPinsOut,   // First port out levels
  output logic      [PORT_W-1:0] firstPortPinsOe,    // First port enables
  input  wire logic [PORT_W-1:0] portBIn,            // Second port pin levels
  output logic      [PORT_W-1:0] portBOut,           // Second port out levels
  output logic      [PORT_W-1:0] portBOe,            // Second port enables
  input  wire logic [PORT_W-1:0] portCIn,            // Third port pin levels
  output logic      [PORT_W-1:0] portCOut,           // Third port out levels
  output logic      [PORT_W-1:0] portCOe,            // Third port enables
  input  wire logic [PORT_W-1:0] portDIn,            // Special port pin levels
  output logic      [PORT_W-1:0] portDOut,           // Special port out levels
  output logic      [PORT_W-1:0] portDOe,            // Special port enables
  output logic      [PORT_W-1:0] portDLevel,         // Filtered special levels
  input  wire logic              spiEnable,          // SPI unit enabled
  input  wire logic              spiMaster,          // SPI in master mode
  input  wire logic              wiredOrDriveSelect, // Open-drain lines 2-5
  input  wire logic              spiMisoOut,         // SPI slave data out
  input  wire logic              spiMosiOut,         // SPI master data out
  input  wire logic              spiSckOut,          // SPI master clock out
  output logic                   ssForSpi,           // Select/fault level to SPI
  input  wire logic              timerOscEnable,     // Timer oscillator enable
  input  wire logic              timerOscDrive,      // Timer oscillator drive
  output logic                   delayOverride       // Short-delay control bit
);
  port_ctl_if paIf ();
  port_ctl_if pbIf ();
  port_ctl_if pcIf ();
  port_ctl_if pdIf ();

  logic [PORT_W-1:0] special;
  logic              oscLatched;
  logic [PORT_W-1:0] want;
  logic [PORT_W-1:0] val;
  logic [PORT_W-1:0] next_dOe;
  logic [PORT_W-1:0] next_dOut;
  logic [PORT_W-1:0] next_rdata;
  logic              next_ss;

  function automatic logic hit(logic [3:0] sel);
    return regWr && regSel == sel;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Port slices

  assign paIf.wdata = regWdata;
  assign paIf.ldDir = hit(SEL_A_DIR);
  assign paIf.ldLatch = hit(SEL_A_DATA);
  assign paIf.openDrain = special[SPEC_OD_BIT];                   // [R7]
  assign pbIf.wdata = regWdata;
  assign pbIf.ldDir = hit(SEL_B_DIR);
  assign pbIf.ldLatch = hit(SEL_B_DATA);
  assign pbIf.openDrain = 1'b0;
  assign pcIf.wdata = regWdata;
  assign pcIf.ldDir = hit(SEL_C_DIR);
  assign pcIf.ldLatch = hit(SEL_C_DATA);
  assign pcIf.openDrain = 1'b0;
  assign pdIf.wdata = regWdata;
  assign pdIf.ldDir = hit(SEL_D_DIR);
  assign pdIf.ldLatch = hit(SEL_D_DATA);
  assign pdIf.openDrain = 1'b0;
  assign portDLevel = pdIf.pinLevel;
  assign delayOverride = special[SPEC_DLY_BIT];

  gp_port u_portA (
    .clock  (clock),
    .rstn   (rstn),
    .ctl    (paIf),
    .pinIn  (firstPortPinsIn),
    .pinOut (firstPortPinsOut),
    .pinOe  (firstPortPinsOe)
  );

  gp_port u_portB (
    .clock  (clock),
    .rstn   (rstn),
    .ctl    (pbIf),
    .pinIn  (portBIn),
    .pinOut (portBOut),
    .pinOe  (portBOe)
  );

  gp_port u_portC (
    .clock  (clock),
    .rstn   (rstn),
    .ctl    (pcIf),
    .pinIn  (portCIn),
    .pinOut (portCOut),
    .pinOe  (portCOe)
  );

  // Special port keeps only the four shared lines programmable; drive is local
  gp_port #(
    .DIR_MASK (D_DIR_MASK)
  ) u_portD (
    .clock  (clock),
    .rstn   (rstn),
    .ctl    (pdIf),
    .pinIn  (portDIn),
    .pinOut (),
    .pinOe  ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Special control register and oscillator hold

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      special <= SPEC_RESET;
    else if (hit(SEL_SPECIAL))
      special <= regWdata & SPEC_MASK;                            // [R16]
  end

  // Software cannot hand the line back; only reset releases it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      oscLatched <= 1'b0;
    else if (timerOscEnable)
      oscLatched <= 1'b1;                                         // [R11]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Special port drive

  always_comb
  begin
    want = '0;
    val = '0;
    if (!spiEnable)
    begin
      want = pdIf.dir;                                            // [R9]
      val = pdIf.latch;
    end
    else if (spiMaster)
    begin
      want[D_MOSI] = pdIf.dir[D_MOSI];                            // [R15]
      val[D_MOSI] = spiMosiOut;
      want[D_SCK] = pdIf.dir[D_SCK];                              // [R15]
      val[D_SCK] = spiSckOut;
      want[D_SS] = pdIf.dir[D_SS];                                // [R14]
      val[D_SS] = pdIf.latch[D_SS];
    end
    else
    begin
      want[D_MISO] = pdIf.dir[D_MISO];                            // [R13] [R15]
      val[D_MISO] = spiMisoOut;
    end
    next_dOe = '0;
    next_dOut = '0;
    for (int i = 0; i < PORT_W; i++)
      {next_dOe[i], next_dOut[i]} = drive_bit(want[i] & D_DIR_MASK[i], val[i],
                                              wiredOrDriveSelect);  // [R8] [R10]
    if (oscLatched || timerOscEnable)
    begin
      next_dOe[D_OSC_OUT] = 1'b1;                                 // [R11]
      next_dOut[D_OSC_OUT] = timerOscDrive;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      portDOe <= '0;
      portDOut <= '0;
    end
    else
    begin
      portDOe <= next_dOe;
      portDOut <= next_dOut;
    end
  end

  // A master with line 5 set as output sees no fault, so the SPI gets idle high
  always_comb
  begin
    next_ss = pdIf.pinLevel[D_SS];                                // [R13]
    if (spiMaster && pdIf.dir[D_SS])
      next_ss = 1'b1;                                             // [R14]
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ssForSpi <= 1'b1;
    else
      ssForSpi <= next_ss;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read

  always_comb
  begin
    if (regSel == SEL_A_DATA)
      next_rdata = port_read(paIf.dir, paIf.latch, paIf.pinLevel); // [R6]
    else if (regSel == SEL_A_DIR)
      next_rdata = paIf.dir;                                      // [R4]
    else if (regSel == SEL_B_DATA)
      next_rdata = port_read(pbIf.dir, pbIf.latch, pbIf.pinLevel); // [R6]
    else if (regSel == SEL_B_DIR)
      next_rdata = pbIf.dir;
    else if (regSel == SEL_C_DATA)
      next_rdata = port_read(pcIf.dir, pcIf.latch, pcIf.pinLevel);
    else if (regSel == SEL_C_DIR)
      next_rdata = pcIf.dir;
    else if (regSel == SEL_D_DATA)
      next_rdata = port_read(pdIf.dir, pdIf.latch, pdIf.pinLevel) & D_READ_MASK; // [R16]
    else if (regSel == SEL_D_DIR)
      next_rdata = pdIf.dir;                                      // [R12]
    else if (regSel == SEL_SPECIAL)
      next_rdata = special;
    else
      next_rdata = '0;                                            // [R16]
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      regRdata <= '0;
    else if (regRd)
      regRdata <= next_rdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_readMix;
    @(posedge clock) disable iff (!rstn)
    regRd && regSel == SEL_A_DATA |=>
      regRdata == (($past(paIf.dir) & $past(paIf.latch)) |
                   (~$past(paIf.dir) & $past(paIf.pinLevel)));
  endproperty
  a_readMix: assert property (p_readMix) else $error("data read mix wrong"); // [R6]

  property p_dirReadZero;
    @(posedge clock) disable iff (!rstn)
    regRd && regSel == SEL_D_DIR |=> (regRdata & ~D_DIR_MASK) == '0;
  endproperty
  a_dirReadZero: assert property (p_dirReadZero) else $error("fixed bits read"); // [R12]

  property p_unmapped;
    @(posedge clock) disable iff (!rstn)
    regRd && regSel > SEL_SPECIAL |=> regRdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // [R16]

  sequence s_oscOn;
    timerOscEnable ##1 !timerOscEnable;
  endsequence

  sequence s_oscHeld;
    portDOe[D_OSC_OUT] [*4];
  endsequence

  property p_oscSticky;
    @(posedge clock) disable iff (!rstn)
    s_oscOn |-> s_oscHeld;
  endproperty
  a_oscSticky: assert property (p_oscSticky) else $error("osc line released"); // [R11]

  property p_fixedIn;
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> !portDOe[0] && !portDOe[PORT_W-1] && !portDOe[PORT_W-2];
  endproperty
  a_fixedIn: assert property (p_fixedIn) else $error("fixed input driven"); // [R10]

  property p_spiOff;
    @(posedge clock) disable iff (!rstn)
    !spiEnable && !wiredOrDriveSelect |=>
      (portDOe & D_DIR_MASK) == ($past(pdIf.dir) & D_DIR_MASK);
  endproperty
  a_spiOff: assert property (p_spiOff) else $error("plain line drive wrong"); // [R9]

  property p_masterIn;
    @(posedge clock) disable iff (!rstn)
    spiEnable && spiMaster |=> !portDOe[D_MISO];
  endproperty
  a_masterIn: assert property (p_masterIn) else $error("master input driven"); // [R15]

  property p_slaveSs;
    @(posedge clock) disable iff (!rstn)
    spiEnable && !spiMaster |=> !portDOe[D_SS] && !portDOe[D_SCK] &&
                                ssForSpi == $past(pdIf.pinLevel[D_SS]);
  endproperty
  a_slaveSs: assert property (p_slaveSs) else $error("slave select wrong"); // [R13]

  property p_masterSs;
    @(posedge clock) disable iff (!rstn)
    spiEnable && spiMaster && !wiredOrDriveSelect && pdIf.dir[D_SS] |=>
      ssForSpi && portDOe[D_SS] && portDOut[D_SS] == $past(pdIf.latch[D_SS]);
  endproperty
  a_masterSs: assert property (p_masterSs) else $error("master line 5 wrong"); // [R14]

  property p_wiredOr;
    @(posedge clock) disable iff (!rstn)
    wiredOrDriveSelect |=> (portDOut & D_DIR_MASK) == '0;
  endproperty
  a_wiredOr: assert property (p_wiredOr) else $error("wired-or drove high"); // [R8]
endmodule

// ---- testbench/board_model.sv ----
// Board-side circuitry seen by one 8-bit port of the block
`timescale 1ns/1ps
module board_model
(
  input  wire logic [7:0] oe,       // Block output enables
  input  wire logic [7:0] drv,      // Block output levels
  input  wire logic [7:0] boardEn,  // Board drives the line
  input  wire logic [7:0] boardDrv, // Board drive level
  output logic      [7:0] level     // Resolved line level
);
  // Lines nobody drives rest high on the board pull-ups, never at a stale value
  assign level = (oe & drv) | (~oe & boardEn & boardDrv) | (~oe & ~boardEn);
endmodule

// ---- testbench/parallel_and_special_io_ports_bench.sv ----
// Self-checking bench for the general and special parallel ports
`timescale 1ns/1ps
module parallel_and_special_io_ports_bench;
  import gpio_pkg::*;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic [3:0] regSel = 4'h0;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [7:0] pinIn [4];
  logic [7:0] pinOut [4];
  logic [7:0] pinOe [4];
  logic [7:0] bDrv [4] = '{default: 8'h00};
  logic [7:0] bEn [4] = '{default: 8'h00};
  logic [7:0] dLevel;
  logic       spiEnable = 1'b0;
  logic       spiMaster = 1'b0;
  logic       wiredOr = 1'b0;
  logic       miso = 1'b0;
  logic       mosi = 1'b0;
  logic       sck = 1'b0;
  logic       oscEn = 1'b0;
  logic       oscDrv = 1'b0;
  logic       ssForSpi;
  logic       delayOverride;
  int         num_errors = 0;
  int         cmp_count = 0;

  always #5 clock = ~clock;

  parallel_io_ports dut (.clock(clock), .rstn(rstn), .regSel(regSel), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .firstPortPinsIn(pinIn[0]), .firstPortPinsOut(pinOut[0]), .firstPortPinsOe(pinOe[0]),
    .portBIn(pinIn[1]), .portBOut(pinOut[1]), .portBOe(pinOe[1]),
    .portCIn(pinIn[2]), .portCOut(pinOut[2]), .portCOe(pinOe[2]),
    .portDIn(pinIn[3]), .portDOut(pinOut[3]), .portDOe(pinOe[3]), .portDLevel(dLevel),
    .spiEnable(spiEnable), .spiMaster(spiMaster), .wiredOrDriveSelect(wiredOr),
    .spiMisoOut(miso), .spiMosiOut(mosi), .spiSckOut(sck), .ssForSpi(ssForSpi),
    .timerOscEnable(oscEn), .timerOscDrive(oscDrv), .delayOverride(delayOverride));

  for (genvar i = 0; i < 4; i++)
  begin : g_board
    board_model board (.oe(pinOe[i]), .drv(pinOut[i]), .boardEn(bEn[i]),
                       .boardDrv(bDrv[i]), .level(pinIn[i]));
  end

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // A spare cycle after each strobe keeps two writes from touching it in one step
  task wr(input logic [3:0] s, input logic [7:0] d);
    regSel = s;
    regWdata = d;
    regWr = 1'b1;
    @(negedge clock);
    regWr = 1'b0;
    @(negedge clock);
  endtask

  task rd(input logic [3:0] s, input logic [7:0] exp, input string what);
    regSel = s;
    regRd = 1'b1;
    @(negedge clock);
    regRd = 1'b0;
    chk(what, exp, regRdata);
    @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (int p = 0; p < 4; p++)
    begin
      rd(4'(2 * p + 1), 8'h00, "direction after reset");
      chk("enables after reset", 8'h00, pinOe[p]);
    end
    rd(4'h9, 8'h00, "unmapped read");
    $display("Test reset done");
  endtask

  task t_general;
    for (int p = 0; p < 3; p++)
    begin
      wr(4'(2 * p + 1), 8'hf0);
      rd(4'(2 * p + 1), 8'hf0, "direction readback");
      wr(4'(2 * p), 8'ha5);
      bEn[p] = 8'h0f;
      bDrv[p] = 8'h3c;
      settle(4);
      chk("output enables", 8'hf0, pinOe[p]);
      chk("output levels", 8'ha5, pinOut[p]);
      rd(4'(2 * p), 8'hac, "mixed data read");
      wr(4'(2 * p + 1), 8'h00);
      wr(4'(2 * p), 8'h5a);
      settle(2);
      chk("inputs undriven", 8'h00, pinOe[p]);
      wr(4'(2 * p + 1), 8'hff);
      settle(2);
      chk("latch kept", 8'h5a, pinOut[p]);
      chk("all outputs", 8'hff, pinOe[p]);
      wr(4'(2 * p + 1), 8'h00);
      bEn[p] = 8'h00;
    end
    $display("Test general ports done");
  endtask

  task t_open_drain;
    wr(SEL_SPECIAL, 8'hff);
    rd(SEL_SPECIAL, 8'h05, "special control");
    chk("delay bit", 8'h01, {7'h00, delayOverride});
    wr(SEL_A_DIR, 8'hff);
    wr(SEL_A_DATA, 8'h0f);
    settle(2);
    chk("open-drain enables", 8'hf0, pinOe[0]);
    chk("open-drain levels", 8'h00, pinOut[0]);
    wr(SEL_SPECIAL, 8'h00);
    wr(SEL_A_DIR, 8'h00);
    $display("Test open drain done");
  endtask

  task t_special;
    // Board pulls lines 0 and 7 low so their reads must show the pin, not the latch
    bEn[3] = 8'h81;
    wr(SEL_D_DIR, 8'hff);
    rd(SEL_D_DIR, 8'h3c, "special direction");
    wr(SEL_D_DATA, 8'hff);
    settle(2);
    chk("special enables", 8'h3c, pinOe[3]);
    rd(SEL_D_DATA, 8'h3e, "special data read");
    chk("special levels", 8'h7e, dLevel);
    bEn[3] = 8'h00;
    wiredOr = 1'b1;
    wr(SEL_D_DATA, 8'h14);
    settle(2);
    chk("wired-or enables", 8'h28, pinOe[3]);
    chk("wired-or levels", 8'h00, pinOut[3] & 8'h3c);
    wiredOr = 1'b0;
    $display("Test special port done");
  endtask

  task t_spi;
    spiEnable = 1'b1;
    spiMaster = 1'b1;
    mosi = 1'b1;
    sck = 1'b1;
    settle(2);
    chk("master enables", 8'h38, pinOe[3]);
    chk("master levels", 8'h18, pinOut[3] & 8'h38);
    chk("select held", 8'h01, {7'h00, ssForSpi});
    wr(SEL_D_DIR, 8'h1c);
    bEn[3] = 8'h20;
    bDrv[3] = 8'h00;
    settle(4);
    chk("fault input", 8'h18, pinOe[3]);
    chk("fault level", 8'h00, {7'h00, ssForSpi});
    spiMaster = 1'b0;
    miso = 1'b1;
    wr(SEL_D_DIR, 8'h3c);
    settle(4);
    chk("slave enables", 8'h04, pinOe[3]);
    chk("slave data", 8'h04, pinOut[3] & 8'h04);
    chk("slave select low", 8'h00, {7'h00, ssForSpi});
    bDrv[3] = 8'h20;
    // Filter needs four edges, the select register one more
    settle(5);
    chk("slave select high", 8'h01, {7'h00, ssForSpi});
    chk("select level", 8'h20, dLevel & 8'h20);
    wr(SEL_D_DIR, 8'h00);
    settle(2);
    chk("slave gated", 8'h00, pinOe[3]);
    spiEnable = 1'b0;
    bEn[3] = 8'h00;
    $display("Test spi sharing done");
  endtask

  task t_timer;
    oscDrv = 1'b1;
    oscEn = 1'b1;
    settle(1);
    oscEn = 1'b0;
    settle(2);
    chk("oscillator enable", 8'h02, pinOe[3]);
    chk("oscillator level", 8'h02, pinOut[3] & 8'h02);
    oscDrv = 1'b0;
    settle(2);
    chk("oscillator follows", 8'h00, pinOut[3] & 8'h02);
    rstn = 1'b0;
    settle(2);
    chk("enables in reset", 8'h00, pinOe[3]);
    rstn = 1'b1;
    settle(2);
    chk("oscillator released", 8'h00, pinOe[3]);
    rd(SEL_B_DIR, 8'h00, "direction after reset");
    $display("Test timer oscillator done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    settle(1);
    t_reset();
    t_general();
    t_open_drain();
    t_special();
    t_spi();
    t_timer();
    report_and_stop();
  end

  // The whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
endmodule
